// file: common/pdw_pkg.sv
// constants, types and decode helpers for the port default tag and wake event registers
package pdw_pkg;

  // port ranges per register class
  localparam logic [3:0] GEN_PORT_LO = 4'h1;
  localparam logic [3:0] GEN_PORT_HI = 4'h7;
  localparam logic [3:0] MAC_PORT_LO = 4'h6;
  localparam logic [3:0] MAC_PORT_HI = 4'h7;
  localparam logic [3:0] PHY_PORT_LO = 4'h0;
  localparam logic [3:0] PHY_PORT_HI = 4'h5;
  localparam int NPORT = 7;

  // address layout
  localparam int ADDR_W = 16;
  localparam int PORT_FLD_LSB = 12;
  localparam logic [11:0] OFS_TAG_HI = 12'h000;
  localparam logic [11:0] OFS_TAG_LO = 12'h001;
  localparam logic [11:0] OFS_WAKE_EVT = 12'h013;
  localparam logic [11:0] OFS_WAKE_EN = 12'h017;

  // tag high byte fields
  localparam int TAG_PCP_LSB = 5;
  localparam int TAG_DEI_BIT = 4;
  localparam int TAG_VIDH_LSB = 0;

  // reset values
  localparam logic [7:0] TAG_HI_RST = 8'h00;
  localparam logic [7:0] TAG_LO_RST = 8'h01;
  localparam logic [2:0] WAKE_FLAG_RST = 3'h0;
  localparam logic [2:0] WAKE_EN_RST = 3'h0;

  // wake event bit positions
  localparam int WAKE_PKT_BIT = 2;
  localparam int WAKE_LINK_BIT = 1;
  localparam int WAKE_ENERGY_BIT = 0;
  localparam int WAKE_W = 3;

  typedef enum logic [2:0] {
    REG_NONE = 3'b000,
    REG_TAG_HI = 3'b001,
    REG_TAG_LO = 3'b010,
    REG_WAKE_EVT = 3'b011,
    REG_WAKE_EN = 3'b100
  } pdw_reg_t;

  function automatic logic pdw_in_range(input logic [3:0] p, input logic [3:0] lo,
                                        input logic [3:0] hi);
    return (p >= lo) && (p <= hi);
  endfunction : pdw_in_range

  function automatic logic pdw_gen_port(input logic [3:0] p);
    return pdw_in_range(p, GEN_PORT_LO, GEN_PORT_HI);
  endfunction : pdw_gen_port

  function automatic logic pdw_phy_port(input logic [3:0] p);
    return pdw_in_range(p, PHY_PORT_LO, PHY_PORT_HI);
  endfunction : pdw_phy_port

endpackage : pdw_pkg

// file: common/pdw_wake_if.sv
// carrier between the register core and the wake flag unit
`timescale 1ns/1ps
interface pdw_wake_if;
  import pdw_pkg::*;
  logic [NPORT:1][WAKE_W-1:0] set_evt;
  logic clr_wr;
  logic en_wr;
  logic [2:0] wport;
  logic [WAKE_W-1:0] wbits;
  logic [NPORT:1][WAKE_W-1:0] flags;
  logic [NPORT:1][WAKE_W-1:0] enables;

  modport core (
    output set_evt,
    output clr_wr,
    output en_wr,
    output wport,
    output wbits,
    input flags,
    input enables
  );

  modport unit (
    input set_evt,
    input clr_wr,
    input en_wr,
    input wport,
    input wbits,
    output flags,
    output enables
  );
endinterface : pdw_wake_if

// file: hw/pdw_port_regs.sv
// per-port default tag and wake event register bank with power event pin
`timescale 1ns/1ps
module pdw_port_regs
  import pdw_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // wake packet detector
  input wire logic [47:0] switch_mac,
  input wire logic wake_pkt_valid,
  input wire logic [3:0] wake_pkt_port,
  input wire logic [47:0] wake_pkt_dst,
  // phy status levels, asynchronous
  input wire logic [NPORT:1] link_up_raw,
  input wire logic [NPORT:1] energy_raw,
  // switch side
  output logic [NPORT:1][15:0] port_tag,
  output logic power_event_pin
);

  pdw_wake_if wif ();

  ////////////////////////////////////////////////////////////////////////////////
  // address decode

  wire [3:0] acc_port;
  wire [11:0] acc_ofs;
  wire port_hit;
  wire [2:0] pidx;
  pdw_reg_t sel;

  assign acc_port = reg_addr[ADDR_W-1:PORT_FLD_LSB];
  assign acc_ofs = reg_addr[PORT_FLD_LSB-1:0];
  assign port_hit = pdw_gen_port(acc_port);
  assign pidx = acc_port[2:0];
  assign sel = !port_hit ? REG_NONE :
               (acc_ofs == OFS_TAG_HI) ? REG_TAG_HI :
               (acc_ofs == OFS_TAG_LO) ? REG_TAG_LO :
               (acc_ofs == OFS_WAKE_EVT) ? REG_WAKE_EVT :
               (acc_ofs == OFS_WAKE_EN) ? REG_WAKE_EN : REG_NONE;

  wire wr_tag_hi;
  wire wr_tag_lo;

  assign wr_tag_hi = reg_wr && (sel == REG_TAG_HI);
  assign wr_tag_lo = reg_wr && (sel == REG_TAG_LO);

  wire [NPORT:1] tag_hi_we;
  wire [NPORT:1] tag_lo_we;

  for (genvar p = 1; p <= NPORT; p++) begin : g_we
    assign tag_hi_we[p] = wr_tag_hi && (pidx == 3'(p));
    assign tag_lo_we[p] = wr_tag_lo && (pidx == 3'(p));
  end

  ////////////////////////////////////////////////////////////////////////////////
  // default tag registers

  logic [NPORT:1][15:0] tag_q;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      tag_q <= {NPORT{TAG_HI_RST, TAG_LO_RST}};
    end else begin
      for (int p = 1; p <= NPORT; p++) begin
        if (tag_hi_we[p]) begin
          tag_q[p][15:8] <= reg_wdata;
        end
        if (tag_lo_we[p]) begin
          tag_q[p][7:0] <= reg_wdata;
        end
      end
    end
  end

  assign port_tag = tag_q;

  ////////////////////////////////////////////////////////////////////////////////
  // phy status synchronisers and rising edge detect

  logic [NPORT:1] link_s1_q;
  logic [NPORT:1] link_s2_q;
  logic [NPORT:1] link_s3_q;
  logic [NPORT:1] nrg_s1_q;
  logic [NPORT:1] nrg_s2_q;
  logic [NPORT:1] nrg_s3_q;

  // no reset: edge detect follows the level through srst, no false rise after it
  always_ff @(posedge core_clk) begin
    link_s1_q <= link_up_raw;
    link_s2_q <= link_s1_q;
    link_s3_q <= link_s2_q;
    nrg_s1_q <= energy_raw;
    nrg_s2_q <= nrg_s1_q;
    nrg_s3_q <= nrg_s2_q;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // wake event sources

  wire pkt_match;
  wire [NPORT:1] link_rise;
  wire [NPORT:1] nrg_rise;

  assign pkt_match = wake_pkt_valid && (wake_pkt_dst == switch_mac);
  assign link_rise = link_s2_q & ~link_s3_q;
  assign nrg_rise = nrg_s2_q & ~nrg_s3_q;

  for (genvar p = 1; p <= NPORT; p++) begin : g_src
    wire phy_ok;
    assign phy_ok = pdw_phy_port(4'(p));
    assign wif.set_evt[p][WAKE_PKT_BIT] = pkt_match && wake_pkt_port == 4'(p);
    assign wif.set_evt[p][WAKE_LINK_BIT] = phy_ok && link_rise[p];
    assign wif.set_evt[p][WAKE_ENERGY_BIT] = phy_ok && nrg_rise[p];
  end

  ////////////////////////////////////////////////////////////////////////////////
  // wake flag unit

  assign wif.clr_wr = reg_wr && (sel == REG_WAKE_EVT);
  assign wif.en_wr = reg_wr && (sel == REG_WAKE_EN);
  assign wif.wport = pidx;
  assign wif.wbits = reg_wdata[WAKE_W-1:0];

  pdw_wake_flags u_flags (
    .core_clk(core_clk),
    .srst(srst),
    .wif(wif)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // power event pin: held while any enabled flag stays set

  wire enabled_set;
  wire any_active;
  logic pin_q;

  assign enabled_set = |(wif.set_evt & wif.enables);
  assign any_active = |(wif.flags & wif.enables);

  always_ff @(posedge core_clk) begin
    if (srst) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= enabled_set || (pin_q && any_active);
    end
  end

  assign power_event_pin = pin_q;

  ////////////////////////////////////////////////////////////////////////////////
  // read path, data in the cycle after the strobe only

  wire [7:0] rd_val;
  logic [7:0] rdata_q;

  assign rd_val = (sel == REG_TAG_HI) ? tag_q[pidx][15:8] :
                  (sel == REG_TAG_LO) ? tag_q[pidx][7:0] :
                  (sel == REG_WAKE_EVT) ? {5'h00, wif.flags[pidx]} :
                  (sel == REG_WAKE_EN) ? {5'h00, wif.enables[pidx]} : 8'h00;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= reg_rd ? rd_val : 8'h00;
    end
  end

  assign reg_rdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  a_port_zero_ignored: assert property (
    (reg_wr && acc_port == 4'h0) |=> $stable(tag_q)
  ) else $error("write to port zero changed a tag");

  a_refused_write: assert property (
    (reg_wr && !port_hit) |=> ($stable(tag_q) && $stable(wif.enables))
  ) else $error("write to a refused port changed a register");

  a_refused_read: assert property (
    (reg_rd && !port_hit) |=> reg_rdata == 8'h00
  ) else $error("read of a refused port returned data");

  a_tag_hi_write: assert property (
    (reg_wr && sel == REG_TAG_HI)
    |=> tag_q[$past(pidx)][15:8] == $past(reg_wdata)
  ) else $error("tag high byte not written");

  a_tag_lo_write: assert property (
    (reg_wr && sel == REG_TAG_LO)
    |=> tag_q[$past(pidx)][7:0] == $past(reg_wdata)
  ) else $error("tag low byte not written");

  a_tag_stable_idle: assert property (
    !reg_wr |=> $stable(tag_q)
  ) else $error("tag changed without a write");

  a_tag_lo_reset: assert property (
    @(posedge core_clk) disable iff (1'b0)
    srst |=> (tag_q[1][7:0] == TAG_LO_RST && tag_q[NPORT][7:0] == TAG_LO_RST)
  ) else $error("tag low byte reset value wrong");

  a_tag_hi_reset: assert property (
    @(posedge core_clk) disable iff (1'b0)
    srst |=> (tag_q[1][15:8] == TAG_HI_RST && tag_q[NPORT][15:8] == TAG_HI_RST)
  ) else $error("tag high byte reset value wrong");

  a_pkt_match_flag: assert property (
    (wake_pkt_valid && wake_pkt_dst == switch_mac && wake_pkt_port == 4'h2)
    |=> wif.flags[2][WAKE_PKT_BIT]
  ) else $error("wake packet flag not set");

  a_pkt_miss_flag: assert property (
    (wake_pkt_valid && wake_pkt_dst != switch_mac && wif.flags[4][WAKE_PKT_BIT] == 1'b0
     && !(reg_wr && sel == REG_WAKE_EVT))
    |=> !wif.flags[4][WAKE_PKT_BIT]
  ) else $error("wake packet flag set on foreign address");

  a_link_up_flag: assert property (
    $rose(link_up_raw[1]) ##1 link_up_raw[1] ##1 link_up_raw[1]
    |=> wif.flags[1][WAKE_LINK_BIT]
  ) else $error("link up flag not set within three cycles");

  a_energy_flag: assert property (
    (nrg_s2_q[5] && !nrg_s3_q[5]) |=> wif.flags[5][WAKE_ENERGY_BIT]
  ) else $error("energy flag not set");

  a_mac_port_quiet: assert property (
    wif.flags[6][1:0] == 2'b00 && wif.flags[7][1:0] == 2'b00
  ) else $error("phy wake bit set on a MAC port");

  a_pin_on_event: assert property (
    enabled_set |=> power_event_pin
  ) else $error("power event pin missed an enabled wake event");

  a_pin_no_cause: assert property (
    (!power_event_pin && !enabled_set) |=> !power_event_pin
  ) else $error("power event pin rose without an enabled event");

  a_pin_release: assert property (
    (power_event_pin && !any_active && !enabled_set) |=> !power_event_pin
  ) else $error("power event pin held with no enabled flag");

  a_pin_reset: assert property (
    @(posedge core_clk) disable iff (1'b0)
    srst |=> !power_event_pin
  ) else $error("power event pin not low after reset");

  a_set_wins: assert property (
    (wif.set_evt[2] != '0)
    |=> (wif.flags[2] & $past(wif.set_evt[2])) == $past(wif.set_evt[2])
  ) else $error("wake event lost against a clear");

  a_flags_reset: assert property (
    @(posedge core_clk) disable iff (1'b0)
    srst |=> (wif.flags == '0 && wif.enables == '0)
  ) else $error("wake flags or enables not reset");

  a_en_write: assert property (
    (reg_wr && sel == REG_WAKE_EN)
    |=> wif.enables[$past(pidx)] == $past(reg_wdata[WAKE_W-1:0])
  ) else $error("wake enable bits not written");

  a_read_timing: assert property (
    reg_rd |=> reg_rdata == $past(rd_val)
  ) else $error("read data not returned in next cycle");

  a_rdata_idle: assert property (
    !reg_rd |=> reg_rdata == 8'h00
  ) else $error("read data stood beyond one cycle");

  a_rdata_reset: assert property (
    @(posedge core_clk) disable iff (1'b0)
    srst |=> reg_rdata == 8'h00
  ) else $error("read data not zero after reset");

  a_reserved_zero: assert property (
    (reg_rd && (sel == REG_WAKE_EVT || sel == REG_WAKE_EN))
    |=> reg_rdata[7:WAKE_W] == '0
  ) else $error("reserved wake bits read as one");

  c_tag_write_read: cover property (wr_tag_lo ##2 reg_rd && sel == REG_TAG_LO);
  c_pin_raise: cover property (enabled_set ##1 power_event_pin);
  c_link_event: cover property (|link_rise ##1 |wif.flags);

endmodule : pdw_port_regs

// file: hw/pdw_wake_flags.sv
// sticky wake event flags and their enable bits, one set per port
`timescale 1ns/1ps
module pdw_wake_flags
  import pdw_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // register core side
  pdw_wake_if.unit wif
);

  logic [NPORT:1][WAKE_W-1:0] flags_q;
  logic [NPORT:1][WAKE_W-1:0] flags_d;
  logic [NPORT:1][WAKE_W-1:0] en_q;
  logic [NPORT:1][WAKE_W-1:0] clr_mask;

  ////////////////////////////////////////////////////////////////////////////////
  // next state: set wins over clear

  for (genvar p = 1; p <= NPORT; p++) begin : g_port
    assign clr_mask[p] = (wif.clr_wr && wif.wport == 3'(p)) ? wif.wbits : '0;
    assign flags_d[p] = (flags_q[p] & ~clr_mask[p]) | wif.set_evt[p];
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      flags_q <= {NPORT{WAKE_FLAG_RST}};
    end else begin
      flags_q <= flags_d;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      en_q <= {NPORT{WAKE_EN_RST}};
    end else if (wif.en_wr) begin
      en_q[wif.wport] <= wif.wbits;
    end
  end

  assign wif.flags = flags_q;
  assign wif.enables = en_q;

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  for (genvar p = 1; p <= NPORT; p++) begin : g_chk
    a_flag_clear: assert property (
      (wif.clr_wr && wif.wport == 3'(p) && wif.set_evt[p] == '0)
      |=> (flags_q[p] & $past(wif.wbits)) == '0
    ) else $error("wake flag not cleared by write of one");
    a_flag_hold: assert property (
      (!(wif.clr_wr && wif.wport == 3'(p)))
      |=> (flags_q[p] & $past(flags_q[p])) == $past(flags_q[p])
    ) else $error("wake flag dropped without a clear");
  end

  c_flag_cleared: cover property (wif.clr_wr ##1 flags_q == '0);

endmodule : pdw_wake_flags

// file: tb/pdw_port_regs_tb_top.sv
// self-checking bench for the port default tag and wake event register bank
`timescale 1ns/1ps
module pdw_port_regs_tb_top
  import pdw_pkg::*;
;
  ////////////////////////////////////////////////////////////////////////////////////////////
  logic core_clk;
  logic srst;
  logic [ADDR_W-1:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic [47:0] switch_mac;
  logic wake_pkt_valid;
  logic [3:0] wake_pkt_port;
  logic [47:0] wake_pkt_dst;
  logic [NPORT:1] link_up_raw;
  logic [NPORT:1] energy_raw;
  logic [NPORT:1][15:0] port_tag;
  logic power_event_pin;
  int miscompares;
  int checked;
  int cycles;
  logic [7:0] rd_q;

  pdw_port_regs i_pdw_port_regs (
    .core_clk(core_clk),
    .srst(srst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .switch_mac(switch_mac),
    .wake_pkt_valid(wake_pkt_valid),
    .wake_pkt_port(wake_pkt_port),
    .wake_pkt_dst(wake_pkt_dst),
    .link_up_raw(link_up_raw),
    .energy_raw(energy_raw),
    .port_tag(port_tag),
    .power_event_pin(power_event_pin)
  );

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  function automatic logic [15:0] ra(input int p, input logic [11:0] ofs);
    ra = {p[3:0], ofs};
  endfunction : ra

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    rd_q = reg_rdata;
    chk({8'h00, rd_q}, {8'h00, exp});
  endtask : rd

  task automatic pkt(input logic [3:0] p, input logic [47:0] dst);
    @(posedge core_clk);
    wake_pkt_valid <= 1'b1;
    wake_pkt_port <= p;
    wake_pkt_dst <= dst;
    @(posedge core_clk);
    wake_pkt_valid <= 1'b0;
  endtask : pkt

  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : idle

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      stop_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    miscompares = 0;
    checked = 0;
    cycles = 0;
    srst = 1'b1;
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    switch_mac = 48'h02A1B2C3D4E5;
    wake_pkt_valid = 1'b0;
    wake_pkt_port = 4'h0;
    wake_pkt_dst = '0;
    link_up_raw = '0;
    energy_raw = '0;
    repeat (3) @(posedge core_clk);
    srst <= 1'b0;
    // reset values of every port
    for (int p = 1; p <= NPORT; p++) begin
      chk(port_tag[p], 16'h0001);
      rd(ra(p, OFS_TAG_HI), 8'h00);
      rd(ra(p, OFS_TAG_LO), 8'h01);
      rd(ra(p, OFS_WAKE_EVT), 8'h00);
    end
    $display("test reset done");
    // tag fields, one idle cycle apart, and refused ports and offsets
    wr(ra(3, OFS_TAG_HI), 8'hA5);
    wr(ra(3, OFS_TAG_LO), 8'h5A);
    idle(1);
    chk(port_tag[3], 16'hA55A);
    chk(port_tag[4], 16'h0001);
    rd(ra(3, OFS_TAG_HI), 8'hA5);
    rd(ra(3, OFS_TAG_LO), 8'h5A);
    wr(ra(7, OFS_TAG_LO), 8'hFE);
    rd(ra(7, OFS_TAG_LO), 8'hFE);
    wr(ra(0, OFS_TAG_LO), 8'h77);
    wr(ra(8, OFS_TAG_LO), 8'h66);
    rd(ra(0, OFS_TAG_LO), 8'h00);
    rd(ra(8, OFS_TAG_LO), 8'h00);
    rd(ra(1, 12'h005), 8'h00);
    chk(port_tag[1], 16'h0001);
    $display("test tags done");
    // wake packet with enable set raises the pin until cleared
    wr(ra(2, OFS_WAKE_EN), 8'h04);
    pkt(4'h2, switch_mac);
    pkt(4'h4, switch_mac ^ 48'h1);
    idle(2);
    chk({15'h0, power_event_pin}, 16'h0001);
    rd(ra(2, OFS_WAKE_EVT), 8'h04);
    rd(ra(4, OFS_WAKE_EVT), 8'h00);
    rd(ra(2, OFS_WAKE_EVT), 8'h04);
    wr(ra(2, OFS_WAKE_EVT), 8'h03);
    rd(ra(2, OFS_WAKE_EVT), 8'h04);
    wr(ra(2, OFS_WAKE_EVT), 8'h04);
    idle(2);
    chk({15'h0, power_event_pin}, 16'h0000);
    rd(ra(2, OFS_WAKE_EVT), 8'h00);
    $display("test wake packet done");
    // link and energy events with enables off leave the pin low
    @(posedge core_clk);
    link_up_raw <= 7'b0000001;
    energy_raw <= 7'b0110000;
    idle(6);
    chk({15'h0, power_event_pin}, 16'h0000);
    rd(ra(1, OFS_WAKE_EVT), 8'h02);
    rd(ra(5, OFS_WAKE_EVT), 8'h01);
    rd(ra(6, OFS_WAKE_EVT), 8'h00);
    wr(ra(1, OFS_WAKE_EN), 8'hFF);
    rd(ra(1, OFS_WAKE_EN), 8'h07);
    idle(2);
    chk({15'h0, power_event_pin}, 16'h0000);
    wr(ra(1, OFS_WAKE_EVT), 8'hFF);
    rd(ra(1, OFS_WAKE_EVT), 8'h00);
    // a fresh energy rise on an enabled port raises the pin
    @(posedge core_clk);
    energy_raw <= 7'b0110001;
    idle(6);
    chk({15'h0, power_event_pin}, 16'h0001);
    rd(ra(1, OFS_WAKE_EVT), 8'h01);
    wr(ra(1, OFS_WAKE_EVT), 8'h01);
    idle(2);
    chk({15'h0, power_event_pin}, 16'h0000);
    $display("test link and energy done");
    // reset in mid-run with link and energy levels still high
    @(posedge core_clk);
    srst <= 1'b1;
    repeat (3) @(posedge core_clk);
    srst <= 1'b0;
    idle(1);
    chk(port_tag[3], 16'h0001);
    chk(port_tag[7], 16'h0001);
    rd(ra(5, OFS_WAKE_EVT), 8'h00);
    rd(ra(1, OFS_WAKE_EN), 8'h00);
    idle(4);
    rd(ra(1, OFS_WAKE_EVT), 8'h00);
    chk({15'h0, power_event_pin}, 16'h0000);
    $display("test reset in run done");
    stop_test();
  end
endmodule : pdw_port_regs_tb_top
